// ### rtl/fan_speed_regulator_gpio.sv
// Purpose: closed-loop fan speed regulator, tach counter and gpio
// Assumes: pins synchronous to core_clk; wishbone classic slave
// Notes:   fan_drive_code is inverse: lower code, higher fan voltage
//
// Summary of operation
// R01: base tick is the oscillator divided by a fixed 128.
// R02: reference tick is the base tick divided by speed plus one.
// R03: reference is compared against the prescaled primary tach pulses.
// R04: tach slower than reference raises fan voltage, else lowers it.
// R05: fan gives two tach pulses per revolution.
// R06: oscillator is internal or external, selected by config bit.
// R07: prescale 1,2,4,8,16 from config bits 2:0.
// R08: mode 10 at config 5:4 selects closed-loop regulation.
// R09: mode 00 full-on, 01 zero voltage, 11 open loop.
// R10: open loop host writes drive code; lower code, higher voltage.
// R11: config bit 3 selects 5V or 12V fan class.
// R12: tach pulses counted in an 8-bit counter.
// R13: counter saturates at 255 on overflow.
// R14: count interval set by a count-time register.
// R15: interval is power-of-two base ticks; count latched, counter restarted.
// R16: tach count ignores the prescaler.
// R17: tach overflow raises an alarm that can drive alert.
// R18: two or five general-purpose pins, host configurable.
// R19: pins 3 and 4: bit 0 drives low, 1 releases.
// R20: pins 0 to 2: code 10 drives low, 11 releases.
// R21: after reset every pin is a released output.
// R22: actual pin levels readable in a status register.
// R23: code 01 at definition bits 1:0 makes pin 0 the alert output.
// R24: alert pin pulled low whenever an enabled alarm is pending.
// R25: code 01 at definition bits 3:2 makes pin 1 a full-on input.
// R26: full-on input low forces maximum fan voltage over any mode.
// R27: closed loop steps drive code by one per reference period, saturating.
//
// Design decisions made here: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module fan_speed_regulator_gpio
  import fan_reg_pkg::*;
#(
  parameter int NUM_GPIO = 5
) (
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [31:0]         wb_dat_i,
  input  wire logic [3:0]          wb_sel_i,
  output var  logic [31:0]         wb_dat_o,
  output var  logic                wb_ack_o,
  input  wire logic                primary_tach_input,
  input  wire logic                ext_osc_in,
  input  wire logic [NUM_GPIO-1:0] gpio_in,
  output var  logic [NUM_GPIO-1:0] gpio_out,
  output var  logic [NUM_GPIO-1:0] gpio_oe,
  output var  logic [7:0]          fan_drive_code,
  output var  logic                fan_12v_sel
);
  // drive-low decode for one pin from the definition register
  function automatic logic pin_drive_low(input logic [7:0] def, input int idx);
    logic r;
    r = 1'b0;
    if (idx < 3) begin
      r = (def[2*idx +: 2] == PIN_LOW2);
    end else begin
      r = ~def[3 + idx];
    end
    return r;
  endfunction : pin_drive_low

  logic [7:0]          target_speed_value;
  logic [7:0]          config_reg;
  logic [7:0]          gpio_def;
  logic [7:0]          drive_code;
  logic [4:0]          alarm_en;
  logic [4:0]          alarm_stat;
  logic [7:0]          tach_count;
  logic [2:0]          count_time;
  logic [MAX_GPIO-1:0] pin_lvl;
  logic                req;
  logic                wr;
  logic                rd;
  logic [31:0]         next_rdata;
  fan_mode_t           mode;
  logic [2:0]          tach_prescale_factor;
  logic                full_on_req;
  logic                alert;

  assign req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr   = req & wb_we_i & wb_sel_i[0];
  assign rd   = req & ~wb_we_i;
  assign mode = fan_mode_t'(config_reg[CFG_MODE_LSB +: 2]);
  assign tach_prescale_factor = config_reg[CFG_PRESCALE_LSB +: 3];
  assign alert = |(alarm_stat & alarm_en);

  generate
    for (genvar p = 0; p < MAX_GPIO; p++) begin : g_lvl
      if (p < NUM_GPIO) begin : g_real
        assign pin_lvl[p] = gpio_in[p];
      end else begin : g_pad
        assign pin_lvl[p] = 1'b1;
      end
    end
  endgenerate

  // hardware full-on override via pin 1
  assign full_on_req = (gpio_def[3:2] == PIN_SPECIAL) && !pin_lvl[1]; // [R25]

  // wishbone slave: one wait state, ack for one cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (wb_adr_i)
      ADDR_SPEED:      next_rdata[7:0] = target_speed_value;
      ADDR_CONFIG:     next_rdata[7:0] = config_reg;
      ADDR_GPIO_DEF:   next_rdata[7:0] = gpio_def;
      ADDR_DAC:        next_rdata[7:0] = drive_code;
      ADDR_ALARM_EN:   next_rdata[4:0] = alarm_en;
      ADDR_ALARM_STAT: next_rdata[4:0] = alarm_stat;
      ADDR_TACH_COUNT: next_rdata[7:0] = tach_count;
      ADDR_COUNT_TIME: next_rdata[2:0] = count_time;
      ADDR_GPIO_STAT:  next_rdata[4:0] = pin_lvl; // [R22]
      default:         next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd) begin
      wb_dat_o <= next_rdata;
    end
  end

  // host-written registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      target_speed_value <= SPEED_RST;
      config_reg         <= CONFIG_RST;
      gpio_def           <= GPIO_DEF_RST; // [R21]
      alarm_en           <= ALARM_EN_RST;
      count_time         <= COUNT_TIME_RST;
    end else if (wr) begin
      if (wb_adr_i == ADDR_SPEED) begin
        target_speed_value <= wb_dat_i[7:0];
      end
      if (wb_adr_i == ADDR_CONFIG) begin
        config_reg <= wb_dat_i[7:0];
      end
      if (wb_adr_i == ADDR_GPIO_DEF) begin
        gpio_def <= wb_dat_i[7:0]; // [R18]
      end
      if (wb_adr_i == ADDR_ALARM_EN) begin
        alarm_en <= wb_dat_i[4:0];
      end
      if (wb_adr_i == ADDR_COUNT_TIME) begin
        count_time <= wb_dat_i[2:0]; // [R14]
      end
    end
  end

  // oscillator: internal divider or external clock edges
  logic [15:0] osc_cnt;
  logic        int_osc_tick;
  logic        ext_q;
  logic        osc_tick;
  logic        base_tick;
  logic        ref_tick;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      osc_cnt      <= 16'h0000;
      int_osc_tick <= 1'b0;
    end else if (osc_cnt == 16'(OSC_DIV_CYCLES - 1)) begin
      osc_cnt      <= 16'h0000;
      int_osc_tick <= 1'b1;
    end else begin
      osc_cnt      <= osc_cnt + 16'h0001;
      int_osc_tick <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ext_q <= 1'b0;
    end else begin
      ext_q <= ext_osc_in;
    end
  end

  // regulation_osc_freq source select
  assign osc_tick = config_reg[CFG_EXT_OSC_BIT] ? (ext_osc_in & ~ext_q) : int_osc_tick; // [R06]

  tick_divider #(.W(8)) u_base_div (
    .core_clk (core_clk),
    .rst      (rst),
    .tick_in  (osc_tick),
    .div_m1   (BASE_DIV_M1), // [R01]
    .tick_out (base_tick)
  );

  tick_divider #(.W(8)) u_ref_div (
    .core_clk (core_clk),
    .rst      (rst),
    .tick_in  (base_tick),
    .div_m1   (target_speed_value), // [R02]
    .tick_out (ref_tick)
  );

  // tach edge detect and prescaler
  logic       tach_q;
  logic       tach_edge;
  logic [3:0] pre_cnt;
  logic [3:0] pre_m1;
  logic       pre_tick;

  assign tach_edge = primary_tach_input & ~tach_q;

  always_comb begin
    unique case (tach_prescale_factor)
      3'h0:    pre_m1 = 4'h0;
      3'h1:    pre_m1 = 4'h1;
      3'h2:    pre_m1 = 4'h3;
      3'h3:    pre_m1 = 4'h7;
      default: pre_m1 = 4'hF; // [R07]
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tach_q   <= 1'b0;
      pre_cnt  <= 4'h0;
      pre_tick <= 1'b0;
    end else begin
      tach_q   <= primary_tach_input;
      pre_tick <= 1'b0;
      if (tach_edge) begin
        if (pre_cnt >= pre_m1) begin
          pre_cnt  <= 4'h0;
          pre_tick <= 1'b1; // [R03] [R05]
        end else begin
          pre_cnt <= pre_cnt + 4'h1;
        end
      end
    end
  end

  // regulator: count prescaled pulses per reference period
  logic [1:0] ref_pulses;
  logic       too_slow;

  assign too_slow = (ref_pulses == 2'h0);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ref_pulses <= 2'h0;
    end else if (ref_tick) begin
      ref_pulses <= {1'b0, pre_tick};
    end else if (pre_tick && ref_pulses != 2'h3) begin
      ref_pulses <= ref_pulses + 2'h1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      drive_code <= DAC_RST;
    end else if (mode == MODE_OPEN) begin
      if (wr && wb_adr_i == ADDR_DAC) begin
        drive_code <= wb_dat_i[7:0]; // [R10]
      end
    end else if (mode == MODE_CLOSED && ref_tick) begin // [R08]
      if (too_slow) begin
        if (drive_code != 8'h00) begin
          drive_code <= drive_code - 8'h01; // [R04] [R27]
        end
      end else if (drive_code != 8'hFF) begin
        drive_code <= drive_code + 8'h01; // [R04] [R27]
      end
    end
  end

  // fan drive output and supply class
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fan_drive_code <= DAC_FULL_ON;
      fan_12v_sel    <= 1'b0;
    end else begin
      fan_12v_sel <= config_reg[CFG_FAN12_BIT]; // [R11]
      if (full_on_req) begin
        fan_drive_code <= DAC_FULL_ON; // [R26]
      end else begin
        unique case (mode)
          MODE_FULL_ON:  fan_drive_code <= DAC_FULL_ON; // [R09]
          MODE_FULL_OFF: fan_drive_code <= DAC_FULL_OFF; // [R09]
          MODE_CLOSED:   fan_drive_code <= drive_code;
          MODE_OPEN:     fan_drive_code <= drive_code;
        endcase
      end
    end
  end

  // tach counter over a programmable interval
  logic [16:0] int_cnt;
  logic [16:0] int_last;
  logic        int_end;
  logic [7:0]  tach_cnt;
  logic        tach_ovf;

  assign int_last = 17'((32'h1 << (CT_SHIFT_BASE + int'(count_time))) - 32'h1);
  assign int_end  = base_tick && (int_cnt >= int_last);
  assign tach_ovf = tach_edge && (tach_cnt == 8'hFE);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      int_cnt <= 17'h00000;
    end else if (int_end) begin
      int_cnt <= 17'h00000; // [R15]
    end else if (base_tick) begin
      int_cnt <= int_cnt + 17'h00001;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tach_cnt   <= 8'h00;
      tach_count <= 8'h00;
    end else if (int_end) begin
      tach_count <= tach_cnt; // [R15]
      tach_cnt   <= 8'h00;
    end else if (tach_edge && tach_cnt != 8'hFF) begin
      tach_cnt <= tach_cnt + 8'h01; // [R12] [R13] [R16]
    end
  end

  // sticky alarms, read of status clears bits whose cause is gone
  logic [4:0] alarm_cause;
  logic       stat_rd;

  assign stat_rd = rd && (wb_adr_i == ADDR_ALARM_STAT);

  always_comb begin
    alarm_cause          = 5'h00;
    alarm_cause[ALM_MIN] = (mode == MODE_CLOSED) && (drive_code == 8'h00);
    alarm_cause[ALM_MAX] = (mode == MODE_CLOSED) && (drive_code == 8'hFF);
    alarm_cause[ALM_OVF] = tach_ovf;
    alarm_cause[ALM_G1]  = ~pin_lvl[1];
    alarm_cause[ALM_G2]  = ~pin_lvl[2];
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      alarm_stat <= 5'h00;
    end else if (stat_rd) begin
      alarm_stat <= alarm_cause;
    end else begin
      alarm_stat <= alarm_stat | alarm_cause; // [R17]
    end
  end

  // open-drain pins: output level always low, enable pulls
  generate
    for (genvar i = 0; i < NUM_GPIO; i++) begin : g_pin
      logic drv;
      if (i == 0) begin : g_alert
        assign drv = pin_drive_low(gpio_def, i)
                   || (gpio_def[1:0] == PIN_SPECIAL && alert); // [R23] [R24]
      end else begin : g_plain
        assign drv = pin_drive_low(gpio_def, i); // [R19] [R20]
      end

      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          gpio_oe[i]  <= 1'b0;
          gpio_out[i] <= 1'b0;
        end else begin
          gpio_oe[i]  <= drv;
          gpio_out[i] <= 1'b0;
        end
      end

      a_pin_drive: assert property (@(posedge core_clk) disable iff (rst) // [R19] [R20]
        pin_drive_low(gpio_def, i) |=> gpio_oe[i])
        else $error("pin defined low is not driven");
    end
  endgenerate

  // checks
  a_full_on_pin: assert property (@(posedge core_clk) disable iff (rst) // [R26]
    full_on_req |=> fan_drive_code == DAC_FULL_ON)
    else $error("full-on input did not force full drive");

  a_full_off_mode: assert property (@(posedge core_clk) disable iff (rst) // [R09]
    (mode == MODE_FULL_OFF && !full_on_req) |=> fan_drive_code == DAC_FULL_OFF)
    else $error("full-off mode did not remove fan voltage");

  a_tach_saturate: assert property (@(posedge core_clk) disable iff (rst) // [R13]
    (tach_cnt == 8'hFF && !int_end) |=> tach_cnt == 8'hFF)
    else $error("tach counter wrapped past 255");

  a_interval_latch: assert property (@(posedge core_clk) disable iff (rst) // [R15]
    int_end |=> (tach_count == $past(tach_cnt)) && (tach_cnt == 8'h00))
    else $error("tach count not latched at interval end");

  a_loop_slow: assert property (@(posedge core_clk) disable iff (rst) // [R27]
    (mode == MODE_CLOSED && ref_tick && too_slow && drive_code != 8'h00)
    |=> drive_code == $past(drive_code) - 8'h01)
    else $error("slow fan did not lower drive code by one");

  a_loop_fast: assert property (@(posedge core_clk) disable iff (rst) // [R04]
    (mode == MODE_CLOSED && ref_tick && !too_slow && drive_code != 8'hFF)
    |=> drive_code == $past(drive_code) + 8'h01)
    else $error("fast fan did not raise drive code by one");

  a_ovf_alarm: assert property (@(posedge core_clk) disable iff (rst) // [R17]
    tach_ovf |=> alarm_stat[ALM_OVF])
    else $error("tach overflow alarm not set");

  a_alert_pin: assert property (@(posedge core_clk) disable iff (rst) // [R24]
    (gpio_def[1:0] == PIN_SPECIAL && alert) |=> gpio_oe[0])
    else $error("alert pin not pulled low");

  a_wb_ack: assert property (@(posedge core_clk) disable iff (rst)
    req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("wishbone ack not a single cycle after request");
endmodule : fan_speed_regulator_gpio
`default_nettype wire

// ### rtl/fan_reg_pkg.sv
// Purpose: shared constants for the fan speed regulator
// Assumes: 8-bit registers on a 32-bit classic wishbone bus
// Notes:   byte offsets, field positions and reset values
package fan_reg_pkg;
  localparam int CLK_FREQ_HZ    = 125_000_000;
  localparam int OSC_FREQ_HZ    = 254_000;
  localparam int OSC_DIV_CYCLES = CLK_FREQ_HZ / OSC_FREQ_HZ;
  localparam logic [7:0] BASE_DIV_M1 = 8'h7F;
  localparam int CT_SHIFT_BASE  = 9;
  localparam int MAX_GPIO       = 5;

  localparam logic [7:0] ADDR_SPEED      = 8'h00;
  localparam logic [7:0] ADDR_CONFIG     = 8'h04;
  localparam logic [7:0] ADDR_GPIO_DEF   = 8'h08;
  localparam logic [7:0] ADDR_DAC        = 8'h0C;
  localparam logic [7:0] ADDR_ALARM_EN   = 8'h10;
  localparam logic [7:0] ADDR_ALARM_STAT = 8'h14;
  localparam logic [7:0] ADDR_TACH_COUNT = 8'h18;
  localparam logic [7:0] ADDR_COUNT_TIME = 8'h1C;
  localparam logic [7:0] ADDR_GPIO_STAT  = 8'h20;

  localparam logic [7:0] SPEED_RST      = 8'h40;
  localparam logic [7:0] CONFIG_RST     = 8'h00;
  localparam logic [7:0] GPIO_DEF_RST   = 8'hFF;
  localparam logic [7:0] DAC_RST        = 8'h00;
  localparam logic [4:0] ALARM_EN_RST   = 5'h00;
  localparam logic [2:0] COUNT_TIME_RST = 3'h3;

  localparam int CFG_PRESCALE_LSB = 0;
  localparam int CFG_FAN12_BIT    = 3;
  localparam int CFG_MODE_LSB     = 4;
  localparam int CFG_EXT_OSC_BIT  = 6;

  localparam int ALM_MIN  = 0;
  localparam int ALM_MAX  = 1;
  localparam int ALM_OVF  = 2;
  localparam int ALM_G1   = 3;
  localparam int ALM_G2   = 4;

  localparam logic [7:0] DAC_FULL_ON  = 8'h00;
  localparam logic [7:0] DAC_FULL_OFF = 8'hFF;
  localparam logic [1:0] PIN_SPECIAL  = 2'h1;
  localparam logic [1:0] PIN_LOW2     = 2'h2;

  typedef enum logic [1:0] {
    MODE_FULL_ON,
    MODE_FULL_OFF,
    MODE_CLOSED,
    MODE_OPEN
  } fan_mode_t;
endpackage : fan_reg_pkg

// ### rtl/tick_divider.sv
// Purpose: divide a tick stream by (div_m1 + 1)
// Assumes: tick_in is a one-cycle pulse
// Notes:   output is a registered one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
  parameter int W = 8
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         tick_in,
  input  wire logic [W-1:0] div_m1,
  output var  logic         tick_out
);
  logic [W-1:0] cnt;

  // tolerant of div_m1 shrinking mid-count
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt      <= '0;
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (tick_in) begin
        if (cnt >= div_m1) begin
          cnt      <= '0;
          tick_out <= 1'b1;
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
    end
  end
endmodule : tick_divider
`default_nettype wire

// ### testbench/fan_model.sv
// Purpose: behavioural fan with tachometer output
// Assumes: lower drive code means higher fan voltage
// Notes:   half a revolution lasts 21 + code cycles; a stalled fan holds tach low
`timescale 1ns/1ps
`default_nettype none
module fan_model (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       spin,
  input  wire logic [7:0] fan_drive_code,
  output var  logic       tach
);
  int cnt;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt  <= 0;
      tach <= 1'b0;
    end else if (!spin) begin
      cnt  <= 0;
      tach <= 1'b0;
    end else if (cnt >= 20 + int'(fan_drive_code)) begin
      cnt  <= 0;
      tach <= 1'b1; // one pulse each half revolution
    end else begin
      cnt <= cnt + 1;
      if (cnt == 2) tach <= 1'b0;
    end
  end
endmodule : fan_model
`default_nettype wire

// ### testbench/tb_top.sv
// Purpose: self-checking bench for the fan speed regulator
// Assumes: external oscillator rises every 4 cycles, so a base tick is 512 cycles
// Notes:   open-drain pins resolved from oe and external pull-downs
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import fan_reg_pkg::*;
  logic        core_clk, rst, wb_cyc, wb_stb, wb_we, wb_ack, tach, spin, sel12;
  logic [7:0]  wb_adr, code;
  logic [31:0] wb_dat, wb_dat_o;
  logic [3:0]  wb_sel;
  logic [1:0]  osc_cnt;
  logic [4:0]  gpio_in, gpio_out, gpio_oe, ext_low;
  int          n_errors, checks, cycles;
  localparam logic [7:0] RA [0:6] = '{ADDR_SPEED, ADDR_CONFIG, ADDR_GPIO_DEF, ADDR_DAC,
                                      ADDR_ALARM_EN, ADDR_COUNT_TIME, 8'h44};
  localparam logic [7:0] RV [0:6] = '{SPEED_RST, CONFIG_RST, GPIO_DEF_RST, DAC_RST,
                                      8'h00, 8'h03, 8'h00};

  assign gpio_in = ~(gpio_oe | ext_low);

  fan_speed_regulator_gpio #(.NUM_GPIO(5)) uut (
    .core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(wb_sel), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack), .primary_tach_input(tach), .ext_osc_in(osc_cnt[1]),
    .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .fan_drive_code(code),
    .fan_12v_sel(sel12));

  fan_model partner (.core_clk(core_clk), .rst(rst), .spin(spin), .fan_drive_code(code),
                     .tach(tach));

  always #4 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    osc_cnt <= osc_cnt + 2'h1;
    cycles  <= cycles + 1;
    if (cycles == 60000) begin
      n_errors++;
      test_done();
    end
  end

  task automatic test_done;
    if (n_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d,
                    output logic [31:0] q);
    @(posedge core_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= a;
    wb_dat <= {24'h0, d};
    wb_sel <= 4'hF;
    do @(posedge core_clk); while (wb_ack !== 1'b1);
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 8'h00, q);
    check(n, q & m, e);
  endtask : rd_chk

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : wait_cyc

  task automatic t_reset;
    check("oe after reset", {27'h0, gpio_oe}, 32'h0);
    check("code after reset", {24'h0, code}, 32'h0);
    wr(8'h44, 8'hA5);
    for (int i = 0; i < 7; i++) rd_chk("reset value", RA[i], 32'hFFFFFFFF, {24'h0, RV[i]});
    wr(ADDR_COUNT_TIME, 8'hFD);
    rd_chk("count time", ADDR_COUNT_TIME, 32'hFFFFFFFF, 32'h05);
  endtask : t_reset

  task automatic t_modes;
    wr(ADDR_CONFIG, 8'h18);
    wait_cyc(3);
    check("code off", {24'h0, code}, 32'hFF);
    check("fan class", {31'h0, sel12}, 32'h1);
    wr(ADDR_DAC, 8'h5A);
    wr(ADDR_CONFIG, 8'h3B);
    wait_cyc(3);
    check("code open refused", {24'h0, code}, 32'h00);
    rd_chk("config", ADDR_CONFIG, 32'hFFFFFFFF, 32'h3B);
    wr(ADDR_DAC, 8'h5A);
    wait_cyc(3);
    check("code open", {24'h0, code}, 32'h5A);
    wr(ADDR_CONFIG, 8'h04);
    wait_cyc(3);
    check("code full on", {24'h0, code}, 32'h00);
    check("fan class", {31'h0, sel12}, 32'h0);
  endtask : t_modes

  task automatic t_gpio;
    wr(ADDR_GPIO_DEF, 8'h8E);
    wait_cyc(3);
    check("pin oe", {27'h0, gpio_oe}, 32'h09);
    check("pin out", {27'h0, gpio_out}, 32'h0);
    ext_low <= 5'h04;
    wait_cyc(3);
    rd_chk("pin status", ADDR_GPIO_STAT, 32'hFFFFFFFF, 32'h12);
    ext_low <= 5'h00;
    wr(ADDR_CONFIG, 8'h10);
    wr(ADDR_GPIO_DEF, 8'hF7);
    ext_low <= 5'h02;
    wait_cyc(3);
    check("forced full on", {24'h0, code}, 32'h00);
    ext_low <= 5'h00;
    wait_cyc(3);
    check("force released", {24'h0, code}, 32'hFF);
  endtask : t_gpio

  task automatic t_stall;
    wr(ADDR_SPEED, 8'h01);
    wr(ADDR_CONFIG, 8'h70);
    wr(ADDR_DAC, 8'h06);
    wr(ADDR_CONFIG, 8'h60);
    wait_cyc(4096);
    check("stall steps", {31'h0, code inside {[8'h01:8'h03]}}, 32'h1);
    wait_cyc(4096);
    check("stall floor", {24'h0, code}, 32'h00);
  endtask : t_stall

  task automatic t_spin;
    spin <= 1'b1;
    wr(ADDR_SPEED, 8'h00);
    wr(ADDR_CONFIG, 8'h70);
    wr(ADDR_DAC, 8'hF0);
    wr(ADDR_CONFIG, 8'h60);
    wait_cyc(10240);
    check("fast ceiling", {24'h0, code}, 32'hFF);
    wr(ADDR_CONFIG, 8'h64);
    wait_cyc(10240);
    check("prescaled", {31'h0, code inside {[8'hE8:8'hFA]}}, 32'h1);
  endtask : t_spin

  task automatic t_ovf;
    wr(ADDR_CONFIG, 8'h00);
    wr(ADDR_ALARM_EN, 8'h04);
    wr(ADDR_GPIO_DEF, 8'hFD);
    for (int i = 0; i < 8000 && gpio_oe[0] !== 1'b1; i++) @(posedge core_clk);
    check("alert pin", {31'h0, gpio_oe[0]}, 32'h1);
    rd_chk("overflow alarm", ADDR_ALARM_STAT, 32'h4, 32'h4);
    wait_cyc(3);
    check("alert cleared", {31'h0, gpio_oe[0]}, 32'h0);
    ext_low <= 5'h04;
    wr(ADDR_ALARM_EN, 8'h10);
    wait_cyc(3);
    rd_chk("pin2 alarm", ADDR_ALARM_STAT, 32'h10, 32'h10);
    wait_cyc(3);
    check("alert held", {31'h0, gpio_oe[0]}, 32'h1);
    wr(ADDR_ALARM_EN, 8'h00);
    wait_cyc(3);
    check("alert off", {31'h0, gpio_oe[0]}, 32'h0);
    ext_low <= 5'h00;
  endtask : t_ovf

  initial begin
    core_clk = 1'b0;
    rst      = 1'b1;
    wb_cyc   = 1'b0;
    wb_stb   = 1'b0;
    wb_we    = 1'b0;
    wb_adr   = 8'h00;
    wb_dat   = 32'h0;
    wb_sel   = 4'h0;
    osc_cnt  = 2'h0;
    ext_low  = 5'h00;
    spin     = 1'b0;
    n_errors = 0;
    checks   = 0;
    cycles   = 0;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_modes();
    t_gpio();
    t_stall();
    t_spin();
    t_ovf();
    test_done();
  end
endmodule : tb_top
`default_nettype wire
